// ---- verilog/wrwdg_defines.vh ----
// Constants for the windowed reset watchdog
`ifndef WRWDG_DEFINES_VH
`define WRWDG_DEFINES_VH
`define WRWDG_CTRL_OFF 12'h000
`define WRWDG_STAT_OFF 12'h004
`define WRWDG_CTRL_RESET 8'h7f
`define WRWDG_ACT_BIT 7
`define WRWDG_TOP_BIT 6
`define WRWDG_PRESCALE 16384
`define WRWDG_PULSE_NS 500
`define WRWDG_CLK_NS 10
`define WRWDG_PULSE_CYC ((`WRWDG_PULSE_NS + `WRWDG_CLK_NS - 1) / `WRWDG_CLK_NS)
`endif

// ---- verilog/wrwdg_top.v ----
// Windowed reset watchdog with APB control register
//
// Contract
// - Counter decrements every 16384 divided-clock cycles.
// - Timeout set in 64 decrement steps.
// - Top bit clearing when active starts reset.
// - Counter runs even while not activated.
// - Activation cleared only by reset.
// - Active with top bit zero resets immediately.
// - Halt while active resets, option selected.
// - Hardware option makes watchdog always active.
// - Writes never reset the prescaler.
// - Low six bits count remaining periods.
// - Control resets to 7Fh, bit layout.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "wrwdg_defines.vh"

module wrwdg_top #(
	parameter PRESCALE = `WRWDG_PRESCALE,
	parameter PULSE_CYC = `WRWDG_PULSE_CYC
) (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Divided oscillator tick, option pins and halt input
	input wire osc_div_clock,
	input wire opt_hw_watchdog,
	input wire opt_reset_on_halt,
	input wire halt_exec,
	// Reset output, active low
	output reg wdg_reset_n
);

	reg [2:0] tick_sync_q;
	reg [1:0] hw_sync_q;
	reg [1:0] halt_opt_sync_q;
	reg [1:0] halt_sync_q;
	reg [15:0] presc_q;
	reg [7:0] ctrl_q;
	reg [7:0] ctrl_d;
	reg [15:0] pulse_q;
	reg trip_d;
	reg cnt_seen_q;
	wire tick_edge;
	wire dec_due;
	wire active;
	wire wr_ctrl;
	wire [7:0] wdata;
	// Counts cut to register width on purpose
	localparam [15:0] PRESC_LAST = PRESCALE - 1;
	localparam [15:0] PULSE_LOAD = PULSE_CYC;

	// Decode of the byte registers
	function is_ctrl;
		input [11:0] a;
		begin
			is_ctrl = (a == `WRWDG_CTRL_OFF);
		end
	endfunction

	function is_stat;
		input [11:0] a;
		begin
			is_stat = (a == `WRWDG_STAT_OFF);
		end
	endfunction

	// Two-flop synchronisers; edge detect reads second and third stages
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_sync_q <= 3'h0;
			hw_sync_q <= 2'h0;
			halt_opt_sync_q <= 2'h0;
			halt_sync_q <= 2'h0;
		end else begin
			tick_sync_q <= {tick_sync_q[1:0], osc_div_clock};
			hw_sync_q <= {hw_sync_q[0], opt_hw_watchdog};
			halt_opt_sync_q <= {halt_opt_sync_q[0], opt_reset_on_halt};
			halt_sync_q <= {halt_sync_q[0], halt_exec};
		end
	end

	assign tick_edge = tick_sync_q[1] & ~tick_sync_q[2];

	// Free-running prescaler, never cleared by writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_q <= 16'h0000;
		end else if (tick_edge) begin
			if (presc_q == PRESC_LAST) begin
				presc_q <= 16'h0000;
			end else begin
				presc_q <= presc_q + 16'h0001;
			end
		end
	end

	assign dec_due = tick_edge && (presc_q == PRESC_LAST);
	assign active = ctrl_q[`WRWDG_ACT_BIT] | hw_sync_q[1];
	assign wr_ctrl = psel && penable && pwrite && is_ctrl(paddr) && pstrb[0];
	assign wdata = pwdata[7:0];

	// Control register next value and trip detect
	always @* begin
		ctrl_d = ctrl_q;
		trip_d = 1'b0;
		if (wr_ctrl) begin
			// Activation is sticky, counter loaded from the write
			ctrl_d[6:0] = wdata[6:0];
			ctrl_d[7] = ctrl_q[7] | wdata[7];
			if ((ctrl_d[7] | hw_sync_q[1]) && !wdata[`WRWDG_TOP_BIT]) begin
				trip_d = 1'b1;
			end
		end else if (dec_due) begin
			ctrl_d[6:0] = ctrl_q[6:0] - 7'h01;
			if (active && ctrl_q[6:0] == 7'h40) begin
				trip_d = 1'b1;
			end
		end
		if (active && halt_opt_sync_q[1] && halt_sync_q[1]) begin
			trip_d = 1'b1;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `WRWDG_CTRL_RESET;
			cnt_seen_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			cnt_seen_q <= cnt_seen_q | dec_due;
		end
	end

	// Reset pulse of fixed length
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_q <= 16'h0000;
			wdg_reset_n <= 1'b1;
		end else begin
			// A trip in the last pulse cycle restarts the pulse; trips earlier in the pulse are dropped
			if (trip_d && pulse_q <= 16'h0001) begin
				pulse_q <= PULSE_LOAD;
				wdg_reset_n <= 1'b0;
			end else if (pulse_q > 16'h0001) begin
				pulse_q <= pulse_q - 16'h0001;
				wdg_reset_n <= 1'b0;
			end else begin
				pulse_q <= 16'h0000;
				wdg_reset_n <= 1'b1;
			end
		end
	end

	// APB: no wait state, answer in access phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !is_ctrl(paddr) && !is_stat(paddr);
			if (psel && !penable && !pwrite && is_ctrl(paddr)) begin
				prdata <= {24'h000000, ctrl_q};
			end else if (psel && !penable && !pwrite && is_stat(paddr)) begin
				prdata <= {28'h0000000, ~wdg_reset_n, halt_sync_q[1], active, cnt_seen_q};
			end else begin
				prdata <= 32'h00000000;
			end
		end
	end

endmodule // wrwdg_top

// ---- bench/wrwdg_checker.sv ----
// Port assertions for the watchdog
`timescale 1ns/1ns
module wrwdg_checker #(parameter PULSE_CYC = 50) (
	input wire pclk, presetn, psel, penable, pwrite, pready, pslverr, halt_exec, wdg_reset_n,
	input wire [11:0] paddr,
	input wire [31:0] pwdata, prdata,
	input wire [3:0] pstrb
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
a_ready_next: assert property (psel && !penable |=> pready) else $error("late");
a_ready_once: assert property (pready |=> !pready) else $error("long");
a_ready_cause: assert property ($rose(pready) |-> $past(psel && !penable)) else $error("ready");
a_err_unmapped: assert property (psel && !penable && paddr[11:3] != 0 |=> pslverr) else $error("err");
a_err_mapped: assert property (psel && !penable && paddr == 12'h000 |=> !pslverr) else $error("err");
a_err_zero: assert property (pslverr |-> prdata == 32'h0) else $error("data");
a_sw_trip: assert property (psel && penable && pwrite && pstrb[0] && paddr == 12'h000
	&& pwdata[7:6] == 2'b10 |-> ##[1:3] !wdg_reset_n) else $error("trip");
a_pulse_len: assert property ($fell(wdg_reset_n) && !halt_exec |-> ##PULSE_CYC wdg_reset_n)
	else $error("pulse");
endmodule // wrwdg_checker
bind wrwdg_top wrwdg_checker #(.PULSE_CYC(PULSE_CYC)) u_chk (.*);

// ---- bench/tb.sv ----
// Self-checking bench for the watchdog
`timescale 1ns/1ns
module tb;
reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, osc = 0, hw = 0, ho = 0, halt = 0;
reg [11:0] paddr = 0;
reg [31:0] pwdata = 0, rd;
wire [31:0] prdata;
wire pready, pslverr, rn;
integer error_cnt = 0, tests_run = 0, cyc = 0, i;
wrwdg_top #(.PRESCALE(4)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .osc_div_clock(osc), .opt_hw_watchdog(hw),
	.opt_reset_on_halt(ho), .halt_exec(halt), .wdg_reset_n(rn));
initial forever #5 pclk = ~pclk;
always @(posedge pclk) begin
	cyc <= cyc + 1;
	if (cyc % 4 == 3) osc <= ~osc;
	if (cyc == 5000) begin
		error_cnt = error_cnt + 1;
		report_and_stop;
	end
end
task chk(input [31:0] nm, input [31:0] e, g);
	begin
		tests_run = tests_run + 1;
		if (g !== e) begin
			error_cnt = error_cnt + 1;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	end
endtask
task apb(input w, input [11:0] a, input [31:0] d);
	begin
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
		@(posedge pclk);
		penable <= 1;
		// Answer read before the edge that samples it
		@(negedge pclk);
		while (pready !== 1'b1) @(negedge pclk);
		rd = pslverr ? 32'h1000 : prdata;
		@(posedge pclk);
		psel <= 0; penable <= 0;
		@(posedge pclk);
	end
endtask
task trip(input integer lo, hi);
	begin
		for (i = 0; rn === 1 && i < hi; i = i + 1) @(posedge pclk);
		chk("trip", 1, i >= lo && i < hi);
	end
endtask
task rst;
	begin
		presetn <= 0; hw <= 0; ho <= 0; halt <= 0;
		repeat (12) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
	end
endtask
initial begin
	rst;
	apb(0, 0, 0); chk("ctrl", 32'h7f, rd);
	apb(0, 12'h008, 0); chk("serr", 32'h1000, rd);
	repeat (100) @(posedge pclk);
	apb(0, 0, 0); chk("run", 1, rd < 32'h7f && rn === 1);
	hw <= 1;
	apb(1, 0, 32'h42); trip(60, 110);
	rst;
	apb(1, 0, 32'hc2);
	apb(1, 0, 32'h42);
	apb(0, 0, 0); chk("act", 3, rd[7:6]);
	trip(50, 110);
	rst;
	apb(1, 0, 32'h80); trip(0, 4);
	rst;
	ho <= 1;
	apb(1, 0, 32'hff);
	halt <= 1;
	trip(0, 8);
	rst;
	report_and_stop;
end
task report_and_stop;
	begin
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	end
endtask
endmodule // tb
